// File: instruction_cycle_timing.sv
`default_nettype none
// Notes on behaviour
// - All instructions of one set start together in one cycle.
// - A set issues only after all earlier sets have finished.
// - Set duration is the longest instruction cycle count inside it.
// - Data arithmetic operations take one cycle.
// - Address arithmetic operations take one cycle.
// - Move with address precalculation takes two cycles, simple one.
// - Computed addressing modes add exactly one cycle to moves and bit mask ops.
// - All operand sizes move in one cycle without precalculation.
// - Bit mask ops read, modify, then write back same location.
// - Bit mask ops take two cycles, three with precalculation.
// - Direct unconditional flow change takes three cycles.
// - Relative flow change takes four cycles.
// - Taken conditional flow change takes four cycles.
// - Untaken conditional flow change takes one cycle.
// - Delayed flow change runs one following set in the delay slot.
// - Delay slot set logically executes before the jump lands.
// - No interrupt between delayed flow change and its slot.
// - Delayed direct totals three, relative four, slot uses part.
// - Calls push onto the software stack.
// - Returns pop from the software stack.
// - Loop skip bypasses loop when counter is zero or negative.
// - Loop exit leaves and branches; loop next jumps to start.
// - Five pipeline stages, two for memory access.
// - Delayed flow change never costs less than one cycle.
// - Delay slot stalls freeze the core, never shorten the count.
module instruction_cycle_timing
    import cycle_timing_pkg::*;
#(
    parameter int LC_W = LOOP_CNT_W
) (
    input  wire logic                   sys_clk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic                   ce_i,
    input  wire logic                   set_valid_i,
    input  wire exec_set_s              set_i,
    output logic                        set_ready_o,
    output logic                        issue_o,
    input  wire logic                   mem_wait_i,
    input  wire logic                   irq_req_i,
    input  wire logic signed [LC_W-1:0] loop_counter_i,
    output logic                        irq_take_o,
    output logic                        busy_o,
    output logic                        delay_slot_o,
    output logic                        stack_push_o,
    output logic                        stack_pop_o,
    output logic                        redirect_o,
    output logic                        mask_read_o,
    output logic                        mask_write_o,
    output logic [CNT_W-1:0]            set_cycles_o,
    output logic [PIPE_STAGES-1:0]      stage_valid_o,
    output logic                        mem_stage_busy_o
);

    function automatic logic [CNT_W-1:0] flow_cycles(
        input flow_kind_e kind,
        input logic       taken
    );
        case (kind)
            FLOW_DIRECT:      return CYC_DIRECT;
            FLOW_RELATIVE:    return CYC_RELATIVE;
            FLOW_COND_DIRECT,
            FLOW_COND_REL:
                return taken ? CYC_COND_TAKEN
                             : CYC_COND_FAILED;
            FLOW_CALL_DIRECT: return CYC_DIRECT;
            FLOW_CALL_REL:    return CYC_RELATIVE;
            FLOW_SUBR_RETURN: return CYC_SUBR_RETURN;
            FLOW_STACK_RET,
            FLOW_EXCEPT_RET:  return CYC_STACK_RET;
            FLOW_LOOP_SKIP:
                return taken ? CYC_SKIP_TAKEN : CYC_SINGLE;
            FLOW_LOOP_EXIT:   return CYC_LOOP_EXIT;
            FLOW_LOOP_NEXT:   return CYC_LOOP_NEXT;
            default:          return CYC_SINGLE;
        endcase
    endfunction

    issue_state_e     state;
    issue_state_e     next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] rcnt;
    logic [CNT_W-1:0] elapsed;
    logic [CNT_W-1:0] read_idx;
    logic             flow_pend;
    logic             mask_act;

    // Set decode
    wire logic [CNT_W-1:0] own_cycles;
    wire logic             has_mask;
    wire logic             mask_pre;

    set_cycle_calc #(
        .SLOTS (NUM_SLOTS)
    ) u_calc (
        .slot_i         (set_i.slot),
        .max_cycles_o   (own_cycles),
        .has_mask_o     (has_mask),
        .mask_precalc_o (mask_pre)
    );

    wire logic is_cond   = set_i.flow == FLOW_COND_DIRECT ||
                           set_i.flow == FLOW_COND_REL;
    wire logic is_skip   = set_i.flow == FLOW_LOOP_SKIP;
    wire logic lc_le_0   = loop_counter_i <= 0;
    wire logic is_call   = set_i.flow == FLOW_CALL_DIRECT ||
                           set_i.flow == FLOW_CALL_REL;
    wire logic is_return = set_i.flow == FLOW_SUBR_RETURN ||
                           set_i.flow == FLOW_STACK_RET ||
                           set_i.flow == FLOW_EXCEPT_RET;
    wire logic in_slot   = state == ST_SLOT;

    wire logic flow_taken = set_i.flow != FLOW_NONE &&
                            (is_cond ? set_i.cond_true :
                             is_skip ? lc_le_0 : 1'b1);
    wire logic [CNT_W-1:0] fcyc = flow_cycles(set_i.flow, flow_taken);

    // Slot sets carry no delayed flow change of their own
    wire logic delayed_cof = set_i.delayed && flow_taken && !in_slot;

    // Delayed set ends after its own instructions; refill runs on
    wire logic [CNT_W-1:0] set_len =
        (delayed_cof || own_cycles >= fcyc) ? own_cycles : fcyc;

    // Issue control
    wire logic advance     = ce_i && !mem_wait_i;
    wire logic set_free    = cnt == '0;
    wire logic refill_free = rcnt == '0;
    wire logic boundary    = set_free && (in_slot || refill_free);
    wire logic irq_grab    = irq_req_i && set_free && refill_free &&
                             !in_slot && !flow_pend;
    wire logic accept      = set_valid_i && set_ready_o;

    assign set_ready_o = advance && boundary && !irq_grab;
    assign irq_take_o  = advance && irq_grab;
    assign issue_o     = accept;

    // Jump lands only after any delay slot set is done
    wire logic redirect_now = advance && flow_pend && refill_free &&
                              set_free && !in_slot;
    assign redirect_o = redirect_now;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE,
            ST_EXEC: begin
                if (accept) begin
                    next_state = delayed_cof ? ST_SLOT : ST_EXEC;
                end else if (advance && set_free && refill_free) begin
                    next_state = ST_IDLE;
                end
            end
            ST_SLOT: begin
                if (accept) begin
                    next_state = ST_EXEC;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    wire logic [CNT_W-1:0] cnt_dec  = set_free ? cnt : cnt - 1'b1;
    wire logic [CNT_W-1:0] rcnt_dec = refill_free ? rcnt : rcnt - 1'b1;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    // Counters hold through every wait cycle, so stalls add, not subtract
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cnt  <= '0;
            rcnt <= '0;
        end else if (accept) begin
            cnt  <= set_len - 1'b1;
            rcnt <= in_slot ? rcnt_dec :
                    (flow_taken ? fcyc - 1'b1 : '0);
        end else if (advance) begin
            cnt  <= cnt_dec;
            rcnt <= rcnt_dec;
        end
    end

    // New taken flow change wins over a landing in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            flow_pend <= 1'b0;
        end else if (accept && flow_taken && !in_slot) begin
            flow_pend <= 1'b1;
        end else if (redirect_now) begin
            flow_pend <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            delay_slot_o <= 1'b0;
        end else if (accept) begin
            delay_slot_o <= in_slot;
        end else if (advance && set_free) begin
            delay_slot_o <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            stack_push_o <= 1'b0;
            stack_pop_o  <= 1'b0;
            set_cycles_o <= '0;
        end else if (ce_i) begin
            stack_push_o <= accept && is_call;
            stack_pop_o  <= accept && is_return;
            if (accept) begin
                set_cycles_o <= set_len;
            end
        end
    end

    // Read, then write back one cycle later; modify has no cycle of its own
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            mask_act <= 1'b0;
            elapsed  <= '0;
            read_idx <= '0;
        end else if (accept) begin
            mask_act <= has_mask;
            elapsed  <= '0;
            read_idx <= mask_pre ? CYC_PRECALC_ADD : '0;
        end else if (advance) begin
            elapsed  <= set_free ? elapsed : elapsed + 1'b1;
            if (set_free) begin
                mask_act <= 1'b0;
            end
        end
    end

    assign mask_read_o  = advance && mask_act &&
                          elapsed == read_idx;
    assign mask_write_o = advance && mask_act &&
                          elapsed == read_idx + 1'b1;
    assign busy_o       = state != ST_IDLE;

    pipe_tracker #(
        .STAGES (PIPE_STAGES)
    ) u_pipe (
        .sys_clk_i        (sys_clk_i),
        .sys_rst_i        (sys_rst_i),
        .advance_i        (advance),
        .inject_i         (accept),
        .stage_valid_o    (stage_valid_o),
        .mem_stage_busy_o (mem_stage_busy_o)
    );

endmodule
`default_nettype wire

// File: cycle_timing_pkg.sv
`default_nettype none
package cycle_timing_pkg;

    localparam int NUM_SLOTS   = 6;
    localparam int CNT_W       = 4;
    localparam int LOOP_CNT_W  = 16;
    localparam int PIPE_STAGES = 5;

    // Address and access stages carry the memory traffic
    localparam logic [PIPE_STAGES-1:0] MEM_STAGE_MASK = 5'h0C;

    localparam logic [CNT_W-1:0] CYC_SINGLE      = 4'h1;
    localparam logic [CNT_W-1:0] CYC_PRECALC_ADD = 4'h1;
    localparam logic [CNT_W-1:0] CYC_MASK_BASE   = 4'h2;
    localparam logic [CNT_W-1:0] CYC_DIRECT      = 4'h3;
    localparam logic [CNT_W-1:0] CYC_RELATIVE    = 4'h4;
    localparam logic [CNT_W-1:0] CYC_COND_TAKEN  = 4'h4;
    localparam logic [CNT_W-1:0] CYC_COND_FAILED = 4'h1;
    localparam logic [CNT_W-1:0] CYC_SUBR_RETURN = 4'h3;
    localparam logic [CNT_W-1:0] CYC_STACK_RET   = 4'h5;
    localparam logic [CNT_W-1:0] CYC_LOOP_EXIT   = 4'h4;
    localparam logic [CNT_W-1:0] CYC_LOOP_NEXT   = 4'h3;
    localparam logic [CNT_W-1:0] CYC_SKIP_TAKEN  = 4'h4;

    typedef enum logic [2:0] {
        CLS_NONE       = 3'h0,
        CLS_DATA_ARITH = 3'h1,
        CLS_ADDR_ARITH = 3'h2,
        CLS_MOVE       = 3'h3,
        CLS_BIT_MASK   = 3'h4
    } inst_class_e;

    typedef enum logic [2:0] {
        AM_SIMPLE      = 3'h0,
        AM_REG_OFFSET  = 3'h1,
        AM_REG_REG     = 3'h2,
        AM_REG_IMM     = 3'h3,
        AM_STACK_IMM   = 3'h4
    } addr_mode_e;

    typedef enum logic [3:0] {
        FLOW_NONE        = 4'h0,
        FLOW_DIRECT      = 4'h1,
        FLOW_RELATIVE    = 4'h2,
        FLOW_COND_DIRECT = 4'h3,
        FLOW_COND_REL    = 4'h4,
        FLOW_CALL_DIRECT = 4'h5,
        FLOW_CALL_REL    = 4'h6,
        FLOW_SUBR_RETURN = 4'h7,
        FLOW_STACK_RET   = 4'h8,
        FLOW_EXCEPT_RET  = 4'h9,
        FLOW_LOOP_SKIP   = 4'hA,
        FLOW_LOOP_EXIT   = 4'hB,
        FLOW_LOOP_NEXT   = 4'hC
    } flow_kind_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_SLOT = 3'b100
    } issue_state_e;

    typedef struct packed {
        logic        valid;
        inst_class_e cls;
        addr_mode_e  mode;
    } inst_s;

    typedef struct packed {
        inst_s [NUM_SLOTS-1:0] slot;
        flow_kind_e            flow;
        logic                  delayed;
        logic                  cond_true;
    } exec_set_s;

    function automatic logic mode_precalc(input addr_mode_e mode);
        return mode != AM_SIMPLE;
    endfunction

endpackage
`default_nettype wire

// File: set_cycle_calc.sv
`default_nettype none
module set_cycle_calc
    import cycle_timing_pkg::*;
#(
    parameter int SLOTS = NUM_SLOTS
) (
    input  wire inst_s [SLOTS-1:0] slot_i,
    output logic [CNT_W-1:0]       max_cycles_o,
    output logic                   has_mask_o,
    output logic                   mask_precalc_o
);

    function automatic logic [CNT_W-1:0] inst_cycles(input inst_s inst);
        logic [CNT_W-1:0] add;
        add = mode_precalc(inst.mode) ? CYC_PRECALC_ADD : '0;
        if (!inst.valid) begin
            return CYC_SINGLE;
        end
        case (inst.cls)
            CLS_DATA_ARITH: return CYC_SINGLE;
            CLS_ADDR_ARITH: return CYC_SINGLE;
            CLS_MOVE:       return CYC_SINGLE + add;
            CLS_BIT_MASK:   return CYC_MASK_BASE + add;
            default:        return CYC_SINGLE;
        endcase
    endfunction

    logic [CNT_W-1:0] cyc  [SLOTS];
    logic [SLOTS-1:0] mask;
    logic [SLOTS-1:0] mpre;

    genvar g;
    generate
        for (g = 0; g < SLOTS; g++) begin : g_slot
            assign cyc[g]  = inst_cycles(slot_i[g]);
            assign mask[g] = slot_i[g].valid &&
                             slot_i[g].cls == CLS_BIT_MASK;
            assign mpre[g] = mask[g] && mode_precalc(slot_i[g].mode);
        end
    endgenerate

    // Longest member sets the pace of the whole set
    always_comb begin
        max_cycles_o = CYC_SINGLE;
        for (int i = 0; i < SLOTS; i++) begin
            if (cyc[i] > max_cycles_o) begin
                max_cycles_o = cyc[i];
            end
        end
    end

    assign has_mask_o     = |mask;
    assign mask_precalc_o = |mpre;

endmodule
`default_nettype wire

// File: pipe_tracker.sv
`default_nettype none
module pipe_tracker
    import cycle_timing_pkg::*;
#(
    parameter int STAGES = PIPE_STAGES
) (
    input  wire logic              sys_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              advance_i,
    input  wire logic              inject_i,
    output logic [STAGES-1:0]      stage_valid_o,
    output logic                   mem_stage_busy_o
);

    logic [STAGES-1:0] stage;

    // Whole pipe holds on a stall; nothing slips past a wait
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            stage <= '0;
        end else if (advance_i) begin
            stage <= {stage[STAGES-2:0], inject_i};
        end
    end

    assign stage_valid_o    = stage;
    assign mem_stage_busy_o = |(stage & MEM_STAGE_MASK);

endmodule
`default_nettype wire

// File: timing_chk_sva.sv
`default_nettype none
module timing_chk
    import cycle_timing_pkg::*;
#(
    parameter int LC_W = LOOP_CNT_W
) (
    input wire logic                   sys_clk_i,
    input wire logic                   sys_rst_i,
    input wire logic                   ce_i,
    input wire logic                   set_valid_i,
    input wire exec_set_s              set_i,
    input wire logic                   set_ready_o,
    input wire logic                   issue_o,
    input wire logic                   mem_wait_i,
    input wire logic                   irq_req_i,
    input wire logic signed [LC_W-1:0] loop_counter_i,
    input wire logic                   irq_take_o,
    input wire logic                   busy_o,
    input wire logic                   delay_slot_o,
    input wire logic                   stack_push_o,
    input wire logic                   stack_pop_o,
    input wire logic                   redirect_o,
    input wire logic                   mask_read_o,
    input wire logic                   mask_write_o,
    input wire logic [CNT_W-1:0]       set_cycles_o,
    input wire logic [PIPE_STAGES-1:0] stage_valid_o,
    input wire logic                   mem_stage_busy_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    logic run;
    logic plain;
    assign run   = ce_i & ~mem_wait_i;
    assign plain = issue_o & ~set_i.delayed;

    sequence s_jump;
        plain && set_i.flow == FLOW_DIRECT && run;
    endsequence
    sequence s_run3;
        run [*3];
    endsequence

    AST_ISSUE: assert property (issue_o == (set_valid_i && set_ready_o))
        else $error("issue without offer and ready");
    AST_FROZEN: assert property (issue_o |-> run)
        else $error("issue during stall");
    AST_DIRECT_CNT: assert property (s_jump |=> set_cycles_o == CYC_DIRECT)
        else $error("direct jump length wrong");
    AST_DIRECT_LAND: assert property (s_jump ##1 s_run3 |-> redirect_o)
        else $error("direct jump did not land on its third cycle");
    AST_REL_CNT: assert property (plain && set_i.flow == FLOW_RELATIVE
        |=> set_cycles_o == CYC_RELATIVE) else $error("relative length wrong");
    AST_COND_FAIL: assert property (issue_o && !set_i.cond_true
        && set_i.flow == FLOW_COND_DIRECT |=> !redirect_o [*2])
        else $error("untaken branch redirected");
    AST_PUSH: assert property (issue_o && set_i.flow inside
        {FLOW_CALL_DIRECT, FLOW_CALL_REL} |=> stack_push_o)
        else $error("call without push");
    AST_POP: assert property (issue_o && set_i.flow inside {FLOW_SUBR_RETURN,
        FLOW_STACK_RET, FLOW_EXCEPT_RET} |=> stack_pop_o)
        else $error("return without pop");
    AST_MASK: assert property (mask_read_o ##1 run |-> mask_write_o)
        else $error("mask read not followed by write");
    AST_MEMSTAGE: assert property (mem_stage_busy_o ==
        (stage_valid_o[3:2] != 2'h0)) else $error("memory stage flag wrong");
    AST_SLOT_IRQ: assert property (issue_o && set_i.delayed && set_i.flow
        inside {FLOW_DIRECT, FLOW_RELATIVE} |=> !irq_take_o)
        else $error("interrupt split delayed pair");
endmodule

bind instruction_cycle_timing timing_chk #(.LC_W(LC_W)) chk (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .set_valid_i(set_valid_i), .set_i(set_i), .set_ready_o(set_ready_o),
    .issue_o(issue_o), .mem_wait_i(mem_wait_i), .irq_req_i(irq_req_i),
    .loop_counter_i(loop_counter_i), .irq_take_o(irq_take_o),
    .busy_o(busy_o), .delay_slot_o(delay_slot_o),
    .stack_push_o(stack_push_o), .stack_pop_o(stack_pop_o),
    .redirect_o(redirect_o), .mask_read_o(mask_read_o),
    .mask_write_o(mask_write_o), .set_cycles_o(set_cycles_o),
    .stage_valid_o(stage_valid_o), .mem_stage_busy_o(mem_stage_busy_o));
`default_nettype wire

// File: mem_model.sv
`default_nettype none
module mem_model (
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       issue_i,
    input  wire logic [3:0] wait_len_i,
    output logic            mem_wait_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] left;
    // Zero wait unless asked; wait starts the cycle after issue
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) left <= 4'h0;
        else if (issue_i && left == 4'h0) left <= wait_len_i;
        else if (left != 4'h0) left <= left - 4'h1;
    end
    assign mem_wait_o = left != 4'h0;
endmodule
`default_nettype wire

// File: instruction_cycle_timing_test.sv
`default_nettype none
module instruction_cycle_timing_test
    import cycle_timing_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk_i = 0, sys_rst_i = 1, ce_i = 1, set_valid_i = 0;
    logic irq_req_i = 0, mem_wait_i;
    logic signed [LOOP_CNT_W-1:0] loop_counter_i = 0;
    exec_set_s set_i = '0;
    logic [3:0] wait_len = 4'h0;
    logic set_ready_o, issue_o, irq_take_o, busy_o, delay_slot_o;
    logic stack_push_o, stack_pop_o, redirect_o, mask_read_o, mask_write_o;
    logic [CNT_W-1:0] set_cycles_o;
    logic [PIPE_STAGES-1:0] stage_valid_o;
    logic mem_stage_busy_o;
    int num_errors = 0, samples_checked = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    instruction_cycle_timing dut (.sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i), .ce_i(ce_i), .set_valid_i(set_valid_i),
        .set_i(set_i), .set_ready_o(set_ready_o), .issue_o(issue_o),
        .mem_wait_i(mem_wait_i), .irq_req_i(irq_req_i),
        .loop_counter_i(loop_counter_i), .irq_take_o(irq_take_o),
        .busy_o(busy_o), .delay_slot_o(delay_slot_o),
        .stack_push_o(stack_push_o), .stack_pop_o(stack_pop_o),
        .redirect_o(redirect_o), .mask_read_o(mask_read_o),
        .mask_write_o(mask_write_o), .set_cycles_o(set_cycles_o),
        .stage_valid_o(stage_valid_o), .mem_stage_busy_o(mem_stage_busy_o));
    mem_model mem (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .issue_i(issue_o), .wait_len_i(wait_len), .mem_wait_o(mem_wait_i));

    task stop_test;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task check_val(input string what, input logic [7:0] exp,
                   input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %0h got %0h", what, exp, got);
        end
    endtask
    task check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %b got %b", what, exp, got);
        end
    endtask

    function automatic exec_set_s mk(inst_class_e c0,
        addr_mode_e m0 = AM_SIMPLE, inst_class_e c1 = CLS_NONE,
        flow_kind_e f = FLOW_NONE, logic d = 0, logic t = 0);
        mk = '0;
        mk.slot[0] = '{1'b1, c0, m0};
        mk.slot[1] = '{c1 != CLS_NONE, c1, AM_SIMPLE};
        mk.flow = f;
        mk.delayed = d;
        mk.cond_true = t;
    endfunction
    function automatic exec_set_s fl(flow_kind_e f, logic d = 0, logic t = 0);
        return mk(CLS_DATA_ARITH, AM_SIMPLE, CLS_NONE, f, d, t);
    endfunction

    task wait_issue;
        int t;
        t = 0;
        #1;
        while (issue_o !== 1'b1 && t < 20) begin
            @(posedge sys_clk_i) #1;
            t++;
        end
        check_bit("issue", 1'b1, issue_o);
    endtask

    // Gap counts edges after the taking edge until ready returns
    task run_set(input exec_set_s s, input int n, input logic push = 0,
                 input logic pop = 0, input int w = 0);
        int k;
        k = 0;
        @(posedge sys_clk_i);
        set_i <= s;
        set_valid_i <= 1;
        wait_len <= 4'(w);
        wait_issue;
        @(posedge sys_clk_i);
        set_valid_i <= 0;
        wait_len <= 4'h0;
        #1;
        check_val("cycles", 8'(n), {4'h0, set_cycles_o});
        check_bit("push", push, stack_push_o);
        check_bit("pop", pop, stack_pop_o);
        while (set_ready_o !== 1'b1 && k < 30) begin
            @(posedge sys_clk_i) #1;
            k++;
        end
        check_val("ready gap", 8'(n - 1 + w), 8'(k));
    endtask
    task skip(input logic signed [LOOP_CNT_W-1:0] lc, input int n);
        @(posedge sys_clk_i) loop_counter_i <= lc;
        run_set(fl(FLOW_LOOP_SKIP), n);
    endtask

    task test_seq;
        run_set(mk(CLS_DATA_ARITH), 1);
        run_set(mk(CLS_ADDR_ARITH), 1);
        run_set(mk(CLS_MOVE), 1);
        for (int i = 1; i < 5; i++) run_set(mk(CLS_MOVE, addr_mode_e'(i)), 2);
        run_set(mk(CLS_BIT_MASK), 2);
        run_set(mk(CLS_BIT_MASK, AM_STACK_IMM, CLS_DATA_ARITH), 3);
        $display("test_seq done");
    endtask
    task test_flow;
        run_set(fl(FLOW_DIRECT), 3);
        run_set(fl(FLOW_RELATIVE), 4);
        run_set(fl(FLOW_COND_DIRECT, 0, 1), 4);
        run_set(fl(FLOW_COND_REL, 0, 1), 4);
        run_set(fl(FLOW_COND_DIRECT), 1);
        run_set(fl(FLOW_CALL_DIRECT), 3, 1);
        run_set(fl(FLOW_CALL_REL), 4, 1);
        run_set(fl(FLOW_SUBR_RETURN), 3, 0, 1);
        run_set(fl(FLOW_STACK_RET), 5, 0, 1);
        run_set(fl(FLOW_EXCEPT_RET), 5, 0, 1);
        run_set(fl(FLOW_LOOP_EXIT), 4);
        run_set(fl(FLOW_LOOP_NEXT), 3);
        skip(0, 4);
        skip(-1, 4);
        skip(1, 1);
        $display("test_flow done");
    endtask
    task test_stall;
        run_set(fl(FLOW_DIRECT), 3, 0, 0, 2);
        @(posedge sys_clk_i);
        ce_i <= 0;
        set_i <= mk(CLS_DATA_ARITH);
        set_valid_i <= 1;
        repeat (3) begin
            #1 check_bit("frozen issue", 1'b0, issue_o);
            @(posedge sys_clk_i);
        end
        ce_i <= 1;
        wait_issue;
        @(posedge sys_clk_i) set_valid_i <= 0;
        $display("test_stall done");
    endtask
    task test_delay;
        int k;
        k = 0;
        @(posedge sys_clk_i);
        set_i <= fl(FLOW_DIRECT, 1);
        set_valid_i <= 1;
        wait_issue;
        @(posedge sys_clk_i);
        set_i <= mk(CLS_DATA_ARITH);
        irq_req_i <= 1;
        #1 check_bit("slot issue", 1'b1, issue_o);
        check_bit("irq in pair", 1'b0, irq_take_o);
        @(posedge sys_clk_i) set_valid_i <= 0;
        #1 check_bit("slot flag", 1'b1, delay_slot_o);
        check_bit("busy", 1'b1, busy_o);
        check_bit("early land", 1'b0, redirect_o);
        @(posedge sys_clk_i) #1;
        check_bit("land", 1'b1, redirect_o);
        while (irq_take_o !== 1'b1 && k < 10) begin
            @(posedge sys_clk_i) #1;
            k++;
        end
        check_bit("irq taken", 1'b1, irq_take_o);
        @(posedge sys_clk_i) irq_req_i <= 0;
        $display("test_delay done");
    endtask

    initial begin
        repeat (10) @(posedge sys_clk_i);
        sys_rst_i <= 0;
        #1 check_val("stages", 8'h00, 8'(stage_valid_o));
        check_bit("ready", 1'b1, set_ready_o);
        test_seq;
        test_flow;
        test_stall;
        test_delay;
        stop_test;
    end
    initial begin
        #100us;
        num_errors++;
        $display("[ERR] watchdog exp done got hang");
        stop_test;
    end
endmodule
`default_nettype wire
